// ### hw/subclk_pkg.sv
// Package for the subclock mode controller: offsets, fields, reset values, types
package subclk_pkg;
   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [11:0] OFF_CLOCK_CTRL = 12'h000;
   localparam logic [11:0] OFF_PERIPH_SEL = 12'h004;
   localparam logic [11:0] OFF_RUN_STATUS = 12'h008;
   // ----------------------------------------------------------------
   // Clock control field positions
   // ----------------------------------------------------------------
   localparam int DIV_LSB = 0;
   localparam int DIV_W = 3;
   localparam int SUB_SEL_POS = 3;
   localparam int MAIN_STOP_POS = 4;
   localparam int SRC_STAT_POS = 5;
   // ----------------------------------------------------------------
   // Peripheral clock select field positions
   // ----------------------------------------------------------------
   localparam int T8_EXT_LSB = 0;
   localparam int CSI_EXT_LSB = 2;
   localparam int UART_EXT_POS = 5;
   localparam int WATCH_SUB_POS = 6;
   localparam int TIMER_H_CH1_SUB_POS = 7;
   localparam int WDT2_SUB_POS = 8;
   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [2:0] RST_DIV = 3'h0;
   localparam logic [8:0] RST_PERIPH_SEL = 9'h000;
   localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_NORMAL,
      MODE_SUB_START,
      MODE_SUB
   } mode_t;
   typedef struct packed {
      logic cpu;
      logic intc;
      logic key_int;
      logic rom_corr;
      logic ext_bus;
      logic timer16;
      logic timer_h0;
      logic timer_h1;
      logic timer8_ch0;
      logic timer8_ch1;
      logic watch;
      logic wdt1;
      logic wdt2;
      logic [2:0] csi_basic;
      logic csi_auto;
      logic two_wire;
      logic first_async_serial;
      logic uart12;
      logic adc;
      logic dac;
      logic rto;
   } periph_run_t;
endpackage

// ### hw/subclock_mode_control.sv
// Subclock operation mode controller with APB register access
//
// Behaviour
// [RULE1] Setting the subclock select bit in normal mode starts subclock operation.
// [RULE2] In subclock operation the system clock source moves from main clock to subclock.
// [RULE3] Setting the main oscillator stop bit halts the main oscillator.
// [RULE4] Once the source status reads 1, watchdog 1 is frozen holding its count.
// [RULE5] Clearing the subclock select bit or a reset ends subclock operation.
// [RULE6] Software restarts a stopped main oscillator and waits its settling before leaving.
// [RULE7] Leaving subclock operation returns the device to normal mode on the main clock.
// [RULE8] Software keeps the divider field unchanged when it changes the select bit.
// [RULE9] Subclock mode with main oscillator running keeps every unit except watchdog 1 enabled.
// [RULE10] With main stopped, CPU, interrupts and key interrupt run; the listed units stop.
// [RULE11] With main stopped, 8-bit timers run only on their external clock input.
// [RULE12] With main stopped, basic clocked serial channels run only on external clock.
// [RULE13] With main stopped, the first UART runs only on its external baud clock.
// [RULE14] With main stopped, watch timer, timer H1 and watchdog 2 run only on subclock.
//
// Implementation choices: register access over APB and the address map.
`timescale 1ns/1ps
module subclock_mode_control
   import subclk_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic use_subclock,
   output logic main_osc_enable,
   output logic wdt1_freeze,
   output logic [DIV_W-1:0] cpu_clock_divider_field,
   output periph_run_t periph_run
);
   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   logic rst_meta;
   logic rst_n;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   logic wr_en;
   logic rd_en;
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && penable && !pwrite;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
      hit = (a == off);
   endfunction

   // ----------------------------------------------------------------
   // Clock control and peripheral select registers
   // ----------------------------------------------------------------
   logic subclock_select_bit;
   logic main_osc_stop_bit;
   logic [DIV_W-1:0] div;
   logic [8:0] periph_sel;
   mode_t mode;
   logic clock_source_status_bit;
   assign clock_source_status_bit = (mode == MODE_SUB);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         subclock_select_bit <= 1'b0;
         main_osc_stop_bit <= 1'b0;
         div <= RST_DIV;
      end else if (wr_en && hit(paddr, OFF_CLOCK_CTRL)) begin
         subclock_select_bit <= pwdata[SUB_SEL_POS]; // [RULE1] [RULE5]
         main_osc_stop_bit <= pwdata[MAIN_STOP_POS]; // [RULE3]
         div <= pwdata[DIV_LSB +: DIV_W];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         periph_sel <= RST_PERIPH_SEL;
      end else if (wr_en && hit(paddr, OFF_PERIPH_SEL)) begin
         periph_sel <= pwdata[8:0];
      end
   end

   // ----------------------------------------------------------------
   // Mode sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode <= MODE_NORMAL; // [RULE5]
      end else begin
         unique case (mode)
            MODE_NORMAL: begin
               if (subclock_select_bit) begin
                  mode <= MODE_SUB_START; // [RULE1]
               end
            end
            MODE_SUB_START: begin
               mode <= subclock_select_bit ? MODE_SUB : MODE_NORMAL;
            end
            MODE_SUB: begin
               if (!subclock_select_bit) begin
                  mode <= MODE_NORMAL; // [RULE5] [RULE7]
               end
            end
            default: begin
               mode <= MODE_NORMAL;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Read data and bus answer
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= UNMAPPED_DATA;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= 1'b0;
         prdata <= UNMAPPED_DATA;
         if (psel && !penable && !pwrite) begin
            if (hit(paddr, OFF_CLOCK_CTRL)) begin
               prdata[DIV_LSB +: DIV_W] <= div;
               prdata[SUB_SEL_POS] <= subclock_select_bit;
               prdata[MAIN_STOP_POS] <= main_osc_stop_bit;
               prdata[SRC_STAT_POS] <= clock_source_status_bit; // [RULE4]
            end else if (hit(paddr, OFF_PERIPH_SEL)) begin
               prdata[8:0] <= periph_sel;
            end else if (hit(paddr, OFF_RUN_STATUS)) begin
               prdata[$bits(periph_run_t)-1:0] <= periph_run;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Clock steering outputs
   // ----------------------------------------------------------------
   logic main_off;
   assign main_off = main_osc_stop_bit;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         use_subclock <= 1'b0;
         main_osc_enable <= 1'b1;
         wdt1_freeze <= 1'b0;
         cpu_clock_divider_field <= RST_DIV;
      end else begin
         use_subclock <= (mode != MODE_NORMAL); // [RULE2] [RULE7]
         main_osc_enable <= !main_off; // [RULE3]
         wdt1_freeze <= clock_source_status_bit; // [RULE4]
         cpu_clock_divider_field <= div;
      end
   end

   // ----------------------------------------------------------------
   // Peripheral run enables
   // ----------------------------------------------------------------
   periph_run_t next_run;
   always_comb begin
      next_run = '1; // [RULE9]
      if (main_off) begin
         next_run.timer16 = 1'b0; // [RULE10]
         next_run.timer_h0 = 1'b0;
         next_run.csi_auto = 1'b0;
         next_run.two_wire = 1'b0;
         next_run.uart12 = 1'b0;
         next_run.adc = 1'b0;
         next_run.dac = 1'b0;
         next_run.rto = 1'b0;
         next_run.wdt1 = 1'b0;
         next_run.timer8_ch0 = periph_sel[T8_EXT_LSB]; // [RULE11]
         next_run.timer8_ch1 = periph_sel[T8_EXT_LSB + 1];
         next_run.csi_basic = periph_sel[CSI_EXT_LSB +: 3]; // [RULE12]
         next_run.first_async_serial = periph_sel[UART_EXT_POS]; // [RULE13]
         next_run.watch = periph_sel[WATCH_SUB_POS]; // [RULE14]
         next_run.timer_h1 = periph_sel[TIMER_H_CH1_SUB_POS];
         next_run.wdt2 = periph_sel[WDT2_SUB_POS];
      end
      if (clock_source_status_bit) begin
         next_run.wdt1 = 1'b0; // [RULE4]
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         periph_run <= '1;
      end else begin
         periph_run <= next_run;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   sequence s_sel_set;
      (mode == MODE_NORMAL) && subclock_select_bit;
   endsequence
   sequence s_sub_reached;
      ##2 (mode == MODE_SUB);
   endsequence

   a_enter_sub: assert property (@(posedge clk) disable iff (!rst_n) // [RULE1]
      s_sel_set |-> ##1 (mode == MODE_SUB_START) or s_sub_reached or ##1 !subclock_select_bit)
      else $error("subclock entry not started");
   a_source_switch: assert property (@(posedge clk) disable iff (!rst_n) // [RULE2]
      (mode == MODE_SUB) |=> use_subclock)
      else $error("system clock not on subclock");
   a_main_halt: assert property (@(posedge clk) disable iff (!rst_n) // [RULE3]
      main_osc_stop_bit |=> !main_osc_enable)
      else $error("main oscillator not halted");
   a_wdt1_hold: assert property (@(posedge clk) disable iff (!rst_n) // [RULE4]
      clock_source_status_bit |=> wdt1_freeze && !periph_run.wdt1)
      else $error("watchdog 1 not frozen");
   a_leave_sub: assert property (@(posedge clk) disable iff (!rst_n) // [RULE5]
      (mode == MODE_SUB) && !subclock_select_bit |=> (mode == MODE_NORMAL))
      else $error("subclock mode not left");
   a_back_normal: assert property (@(posedge clk) disable iff (!rst_n) // [RULE7]
      (mode == MODE_NORMAL) && $past(mode == MODE_NORMAL) |=> !use_subclock)
      else $error("main clock not restored");
   a_all_run: assert property (@(posedge clk) disable iff (!rst_n) // [RULE9]
      !main_off && !clock_source_status_bit |=> periph_run.timer16 && periph_run.adc)
      else $error("peripheral stopped with main running");
   a_stop_set: assert property (@(posedge clk) disable iff (!rst_n) // [RULE10]
      main_off |=> !periph_run.timer16 && !periph_run.uart12 && periph_run.cpu)
      else $error("stop set wrong with main stopped");
   a_ext_clocks: assert property (@(posedge clk) disable iff (!rst_n) // [RULE11]
      main_off |=> periph_run.timer8_ch0 == $past(periph_sel[T8_EXT_LSB])
         && periph_run.first_async_serial == $past(periph_sel[UART_EXT_POS]))
      else $error("external clock gating wrong");

   // ----------------------------------------------------------------
   // Peripheral gating assertions
   // ----------------------------------------------------------------
   sequence s_main_stopped;
      main_off;
   endsequence
   sequence s_main_running;
      !main_off && !clock_source_status_bit;
   endsequence

   a_t8_ch1_ext: assert property (@(posedge clk) disable iff (!rst_n) // [RULE11]
      s_main_stopped |=> periph_run.timer8_ch1 == $past(periph_sel[T8_EXT_LSB + 1]))
      else $error("second 8-bit timer gating wrong");

   a_serial_ext: assert property (@(posedge clk) disable iff (!rst_n) // [RULE12]
      s_main_stopped |=> periph_run.csi_basic == $past(periph_sel[CSI_EXT_LSB +: 3]))
      else $error("basic serial gating wrong");

   a_first_async_serial_ext: assert property (@(posedge clk) disable iff (!rst_n) // [RULE13]
      s_main_stopped |=> periph_run.first_async_serial == $past(periph_sel[UART_EXT_POS]))
      else $error("first UART gating wrong");

   a_sub_timers: assert property (@(posedge clk) disable iff (!rst_n) // [RULE14]
      s_main_stopped |=> periph_run.watch == $past(periph_sel[WATCH_SUB_POS])
         && periph_run.timer_h1 == $past(periph_sel[TIMER_H_CH1_SUB_POS])
         && periph_run.wdt2 == $past(periph_sel[WDT2_SUB_POS]))
      else $error("subclock timer gating wrong");

   a_rest_stop: assert property (@(posedge clk) disable iff (!rst_n) // [RULE10]
      s_main_stopped |=> !periph_run.timer_h0 && !periph_run.csi_auto && !periph_run.two_wire
         && !periph_run.adc && !periph_run.dac && !periph_run.rto && !periph_run.wdt1)
      else $error("unit left running with main stopped");

   a_core_run: assert property (@(posedge clk) disable iff (!rst_n) // [RULE10]
      s_main_stopped |=> periph_run.intc && periph_run.key_int)
      else $error("core units stopped with main stopped");

   a_all_units: assert property (@(posedge clk) disable iff (!rst_n) // [RULE9]
      s_main_running |=> periph_run == '1)
      else $error("unit stopped in normal running");

   a_sub_main_on: assert property (@(posedge clk) disable iff (!rst_n) // [RULE9]
      clock_source_status_bit && !main_off |=> periph_run.timer16 && periph_run.csi_auto
         && periph_run.uart12 && periph_run.rom_corr && periph_run.ext_bus)
      else $error("unit stopped in subclock with main running");

   // ----------------------------------------------------------------
   // Mode and clock steering assertions
   // ----------------------------------------------------------------
   sequence s_entry;
      (mode == MODE_NORMAL) && subclock_select_bit ##1 subclock_select_bit;
   endsequence

   a_status_reach: assert property (@(posedge clk) disable iff (!rst_n) // [RULE1]
      (mode == MODE_SUB_START) && subclock_select_bit |=> clock_source_status_bit)
      else $error("subclock status not reached");

   a_sub_hold: assert property (@(posedge clk) disable iff (!rst_n) // [RULE2]
      s_entry |=> use_subclock)
      else $error("system clock not moved to subclock");

   a_main_restart: assert property (@(posedge clk) disable iff (!rst_n) // [RULE3]
      !main_osc_stop_bit |=> main_osc_enable)
      else $error("main oscillator not restarted");

   a_freeze_wait: assert property (@(posedge clk) disable iff (!rst_n) // [RULE4]
      (mode == MODE_SUB_START) |=> !wdt1_freeze)
      else $error("watchdog 1 frozen too early");

   a_unfreeze: assert property (@(posedge clk) disable iff (!rst_n) // [RULE7]
      !clock_source_status_bit |=> !wdt1_freeze && periph_run.wdt1 == !$past(main_off))
      else $error("watchdog 1 not released");

   a_leave_start: assert property (@(posedge clk) disable iff (!rst_n) // [RULE5]
      (mode == MODE_SUB_START) && !subclock_select_bit |=> (mode == MODE_NORMAL))
      else $error("aborted entry not undone");

   // ----------------------------------------------------------------
   // Bus and register assertions
   // ----------------------------------------------------------------
   a_ready_pulse: assert property (@(posedge clk) disable iff (!rst_n)
      pready |=> !pready)
      else $error("ready held past one cycle");

   a_access_ready: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_en || rd_en) |-> pready)
      else $error("access phase without ready");

   a_ctrl_status: assert property (@(posedge clk) disable iff (!rst_n) // [RULE4]
      psel && !penable && !pwrite && (paddr == OFF_CLOCK_CTRL)
         |=> prdata[SRC_STAT_POS] == $past(clock_source_status_bit))
      else $error("status bit read wrong");

   a_read_status: assert property (@(posedge clk) disable iff (!rst_n)
      psel && !penable && !pwrite && (paddr == OFF_RUN_STATUS)
         |=> prdata[$bits(periph_run_t)-1:0] == $past(periph_run))
      else $error("run status read wrong");

   a_unmapped_zero: assert property (@(posedge clk) disable iff (!rst_n)
      psel && !penable && !pwrite && (paddr != OFF_CLOCK_CTRL) && (paddr != OFF_PERIPH_SEL)
         && (paddr != OFF_RUN_STATUS) |=> prdata == UNMAPPED_DATA)
      else $error("unmapped read not zero");

   a_div_copy: assert property (@(posedge clk) disable iff (!rst_n)
      1'b1 |=> cpu_clock_divider_field == $past(div))
      else $error("divider copy wrong");
endmodule

// ### dv/subclock_mode_control_tb.sv
// Self-checking bench for the subclock mode controller
`timescale 1ns/1ps
module subclock_mode_control_tb;
   import subclk_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic [31:0] seed = 32'h24;
   logic pready, pslverr, use_subclock, main_osc_enable, wdt1_freeze;
   logic [DIV_W-1:0] cpu_clock_divider_field;
   logic [2:0] dv;
   logic [8:0] ps;
   logic [31:0] rv;
   periph_run_t periph_run, msk, full_sub;
   int failures = 0;
   int check_count = 0;
   subclock_mode_control subclock_mode_control_i (.clk(clk), .nrst(nrst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .use_subclock(use_subclock),
      .main_osc_enable(main_osc_enable), .wdt1_freeze(wdt1_freeze),
      .cpu_clock_divider_field(cpu_clock_divider_field), .periph_run(periph_run));
   always #12.5 clk = ~clk;
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic periph_run_t exp_run(input logic [8:0] s);
      periph_run_t r;
      r = '0;
      r.cpu = 1'b1;
      r.intc = 1'b1;
      r.key_int = 1'b1;
      r.timer8_ch0 = s[T8_EXT_LSB];
      r.timer8_ch1 = s[T8_EXT_LSB+1];
      r.csi_basic = s[CSI_EXT_LSB +: 3];
      r.first_async_serial = s[UART_EXT_POS];
      r.watch = s[WATCH_SUB_POS];
      r.timer_h1 = s[TIMER_H_CH1_SUB_POS];
      r.wdt2 = s[WDT2_SUB_POS];
      return r;
   endfunction
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_bit(input string n, input logic e, input logic g);
      chk(n, {31'h0, e}, {31'h0, g});
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      penable <= 1'b0;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      chk_bit("pready", 1'b1, pready);
      rd = prdata;
      chk_bit("pslverr", 1'b0, pslverr);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic settle();
      repeat (4) @(posedge clk);
      #1;
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      #(25 * 20000);
      failures++;
      close_out();
   end
   initial begin
      msk = '1;
      msk.rom_corr = 1'b0;
      msk.ext_bus = 1'b0;
      full_sub = '1;
      full_sub.wdt1 = 1'b0;
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk_bit("use_subclock", 1'b0, use_subclock);
      chk_bit("main_osc_enable", 1'b1, main_osc_enable);
      chk("periph_run", 32'h007F_FFFF, {9'h0, periph_run});
      apb(1'b0, OFF_CLOCK_CTRL, 32'h0);
      chk("ctrl", 32'h0, rd);
      apb(1'b0, OFF_PERIPH_SEL, 32'h0);
      chk("psel_reg", 32'h0, rd);
      apb(1'b0, OFF_RUN_STATUS, 32'h0);
      chk("status", 32'h007F_FFFF, rd);
      apb(1'b0, 12'hFFC, 32'h0);
      chk("unmapped", UNMAPPED_DATA, rd);
      $display("test reset done");
      for (int i = 0; i < 8; i++) begin
         rv = rnd();
         dv = rv[2:0];
         rv = rnd();
         ps = (i == 0) ? 9'h000 : (i == 1) ? 9'h1FF : rv[8:0];
         apb(1'b1, OFF_PERIPH_SEL, {23'h0, ps});
         apb(1'b1, 12'hFFC, rnd());
         apb(1'b0, OFF_PERIPH_SEL, 32'h0);
         chk("psel_reg", {23'h0, ps}, rd);
         apb(1'b1, OFF_CLOCK_CTRL, {29'h1, dv});
         settle();
         chk_bit("use_subclock", 1'b1, use_subclock);
         chk_bit("wdt1_freeze", 1'b1, wdt1_freeze);
         chk("run_main_on", {9'h0, full_sub}, {9'h0, periph_run});
         apb(1'b0, OFF_CLOCK_CTRL, 32'h0);
         chk("ctrl_sub", {29'h5, dv}, rd);
         apb(1'b1, OFF_CLOCK_CTRL, {29'h3, dv});
         settle();
         chk_bit("main_osc_enable", 1'b0, main_osc_enable);
         chk("run_main_off", {9'h0, exp_run(ps) & msk}, {9'h0, periph_run & msk});
         apb(1'b0, OFF_RUN_STATUS, 32'h0);
         chk("status", {9'h0, exp_run(ps) & msk}, rd & {9'h0, msk});
         apb(1'b1, OFF_CLOCK_CTRL, {29'h1, dv});
         repeat (20) @(posedge clk);
         apb(1'b1, OFF_CLOCK_CTRL, {29'h0, dv});
         settle();
         chk_bit("use_subclock", 1'b0, use_subclock);
         chk_bit("wdt1_freeze", 1'b0, wdt1_freeze);
         chk("run_normal", 32'h007F_FFFF, {9'h0, periph_run});
         chk("divider", {29'h0, dv}, {29'h0, cpu_clock_divider_field});
         apb(1'b0, OFF_CLOCK_CTRL, 32'h0);
         chk("ctrl_normal", {29'h0, dv}, rd);
      end
      $display("test mode cycles done");
      apb(1'b1, OFF_CLOCK_CTRL, {29'h3, dv});
      settle();
      @(posedge clk);
      nrst <= 1'b0;
      #1;
      chk_bit("use_subclock", 1'b0, use_subclock);
      chk_bit("main_osc_enable", 1'b1, main_osc_enable);
      chk_bit("wdt1_freeze", 1'b0, wdt1_freeze);
      chk("run_reset", 32'h007F_FFFF, {9'h0, periph_run});
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      apb(1'b0, OFF_CLOCK_CTRL, 32'h0);
      chk("ctrl_after_reset", 32'h0, rd);
      $display("test reset exit done");
      close_out();
   end
endmodule
